// ### watchdog_and_wakeup_control.sv
`timescale 1ns/100ps
module watchdog_and_wakeup_control
   import wdt_pkg::*;
#(
   parameter int unsigned PORTA_W = 8,
   parameter int unsigned INT_W = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Low-speed oscillators and pins.
   input wire logic external_low_crystal,
   input wire logic internal_low_rc_osc,
   input wire logic ext_reset_n,
   input wire logic usb_reset,
   input wire logic [PORTA_W-1:0] porta_in,
   // Processor core.
   input wire logic halt_exec,
   input wire logic watchdog_clear_instruction,
   input wire logic [INT_W-1:0] int_pending,
   input wire logic [INT_W-1:0] int_enable,
   input wire logic stack_full,
   input wire logic [EXT_FLAGS_W-1:0] other_fault_set,
   // Events to the core.
   output core_event_type core_event,
   output logic in_sleep
);
   import wdt_pkg::*;

   localparam int unsigned PIN_W = PORTA_W + 4;

   logic [PIN_W-1:0] pin_s1_q;
   logic [PIN_W-1:0] pin_s2_q;
   logic [PIN_W-1:0] pin_s3_q;
   logic lxt_rise;
   logic internal_low_rc_osc_rise;
   logic ext_rst_act;
   logic usb_rst_act;
   logic [PORTA_W-1:0] pa_now;
   logic [PORTA_W-1:0] pa_prev;

   logic [7:0] ctrl_q;
   logic [FLAGS_W-1:0] flags_q;
   logic sub_clock_select_q;
   logic [PORTA_W-1:0] porta_wake_enable_q;
   logic timeout_q;
   logic power_down_q;
   logic asleep_q;
   logic [INT_W-1:0] int_mask_q;
   logic [CNT_W-1:0] cnt_q;
   logic [1:0] fault_cnt_q;

   logic [KEY_W-1:0] key;
   logic enabled;
   logic key_bad;
   logic key_fault;
   logic wdt_tick;
   logic [CNT_W-1:0] term;
   logic overflow;
   logic wdt_clear;
   logic [INT_W-1:0] int_new;
   logic int_wake;
   logic vec_ok;
   logic porta_wake;
   logic pin_reset_wake;
   logic any_wake;
   core_event_type event_d;

   logic [7:0] awaddr_q;
   logic aw_full_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_full_q;
   logic wr_go;
   logic wr_lane0;
   logic [31:0] rdata_d;
   logic rd_hit;

   // Every pin passes two flops; the third stage only feeds edge detection.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= {external_low_crystal, internal_low_rc_osc, ext_reset_n, usb_reset, porta_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign lxt_rise = pin_s2_q[PIN_W-1] && !pin_s3_q[PIN_W-1];
   assign internal_low_rc_osc_rise = pin_s2_q[PIN_W-2] && !pin_s3_q[PIN_W-2];
   assign ext_rst_act = !pin_s2_q[PIN_W-3] && pin_s3_q[PIN_W-3];
   assign usb_rst_act = pin_s2_q[PIN_W-4];
   assign pa_now = pin_s2_q[PORTA_W-1:0];
   assign pa_prev = pin_s3_q[PORTA_W-1:0];

   assign key = ctrl_q[KEY_LSB +: KEY_W];
   assign enabled = (key == KEY_ENABLE);
   assign key_bad = (key != KEY_ENABLE) && (key != KEY_DISABLE);
   assign wdt_tick = sub_clock_select_q ? lxt_rise : internal_low_rc_osc_rise;
   assign term = CNT_W'((19'h1 << period_exp(ctrl_q[SEL_W-1:0])) - 19'h1);
   assign overflow = enabled && wdt_tick && (cnt_q == term);
   assign wdt_clear = key_fault || watchdog_clear_instruction || halt_exec || overflow || !enabled;

   // A bad key must be seen across the RC edge count before it resets.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_cnt_q <= '0;
      end else if (!key_bad || key_fault) begin
         fault_cnt_q <= '0;
      end else if (internal_low_rc_osc_rise) begin
         fault_cnt_q <= fault_cnt_q + 2'h1;
      end
   end

   assign key_fault = key_bad && (fault_cnt_q == KEY_FAULT_EDGES);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (wdt_clear) begin
         cnt_q <= '0;
      end else if (wdt_tick) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // Wake-up source decoding while halted.
   assign int_new = int_pending & ~int_mask_q;
   assign int_wake = |int_new;
   assign vec_ok = (|(int_new & int_enable)) && !stack_full;
   assign porta_wake = |(pa_prev & ~pa_now & porta_wake_enable_q);
   assign pin_reset_wake = ext_rst_act || usb_rst_act;
   assign any_wake = pin_reset_wake || porta_wake || int_wake || overflow;

   always_comb begin
      event_d = '0;
      event_d.full_reset = key_fault || (overflow && !asleep_q) || (asleep_q && pin_reset_wake);
      event_d.pc_sp_reset = asleep_q && overflow && !event_d.full_reset;
      event_d.pc_clear = event_d.full_reset || event_d.pc_sp_reset;
      event_d.wake = asleep_q && any_wake;
      if (asleep_q && !event_d.full_reset && !overflow) begin
         if (int_wake && vec_ok) begin
            event_d.int_vector = 1'b1;
         end else if (int_wake || porta_wake) begin
            event_d.resume_next = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_event <= '0;
      end else begin
         core_event <= event_d;
      end
   end

   // Sleep state; the pending snapshot blocks stale requests from waking.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         asleep_q <= 1'b0;
         int_mask_q <= '0;
      end else if (halt_exec) begin
         asleep_q <= 1'b1;
         int_mask_q <= int_pending;
      end else if (any_wake || key_fault) begin
         asleep_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_sleep <= 1'b0;
      end else begin
         in_sleep <= asleep_q;
      end
   end

   // Status flags: a setting event wins over a clearing one.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_q <= 1'b0;
      end else if (overflow) begin
         timeout_q <= 1'b1;
      end else if (halt_exec) begin
         timeout_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_down_q <= 1'b0;
      end else if (halt_exec) begin
         power_down_q <= 1'b1;
      end else if (watchdog_clear_instruction) begin
         power_down_q <= 1'b0;
      end
   end

   // AXI4-Lite write address and data are taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_full_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_full_q <= 1'b1;
         awaddr_q <= s_axi_awaddr[7:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_full_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_full_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
         w_full_q <= 1'b0;
      end
   end

   assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_lane0 = wr_go && wstrb_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         case (awaddr_q)
            CTRL_OFFSET, FLAGS_OFFSET, STATUS_OFFSET, CLKSEL_OFFSET, WAKE_EN_OFFSET: begin
               s_axi_bresp <= RESP_OKAY;
            end
            default: begin
               s_axi_bresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register; a key fault reloads the power-on value.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (key_fault) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_lane0 && awaddr_q == CTRL_OFFSET) begin
         ctrl_q <= wdata_q[7:0];
      end
   end

   // Reset cause flags: writing 0 clears, writing 1 keeps, a set wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= '0;
      end else begin
         flags_q <= ((wr_lane0 && awaddr_q == FLAGS_OFFSET) ? (flags_q & wdata_q[FLAGS_W-1:0]) : flags_q)
                    | {other_fault_set, key_fault};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sub_clock_select_q <= 1'b0;
         porta_wake_enable_q <= '0;
      end else if (wr_lane0) begin
         if (awaddr_q == CLKSEL_OFFSET) begin
            sub_clock_select_q <= wdata_q[0];
         end
         if (awaddr_q == WAKE_EN_OFFSET) begin
            porta_wake_enable_q <= wdata_q[PORTA_W-1:0];
         end
      end
   end

   // Read decode.
   always_comb begin
      rdata_d = '0;
      rd_hit = 1'b1;
      case (s_axi_araddr[7:0])
         CTRL_OFFSET: rdata_d = 32'(ctrl_q);
         FLAGS_OFFSET: rdata_d = 32'(flags_q);
         STATUS_OFFSET: begin
            rdata_d[STAT_TIMEOUT] = timeout_q;
            rdata_d[STAT_POWER_DOWN] = power_down_q;
            rdata_d[STAT_ASLEEP] = asleep_q;
         end
         CLKSEL_OFFSET: rdata_d = 32'(sub_clock_select_q);
         WAKE_EN_OFFSET: rdata_d = 32'(porta_wake_enable_q);
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_d;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// ### watchdog_and_wakeup_control_bench.sv
`timescale 1ns/100ps
module watchdog_and_wakeup_control_bench;
   import wdt_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_sleep;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic external_low_crystal = 0, internal_low_rc_osc = 0, ext_reset_n = 1, usb_reset = 0;
   logic halt_exec = 0, watchdog_clear_instruction = 0, stack_full = 0, rc_run = 1;
   logic [7:0] porta_in = 8'hff, int_pending = '0, int_enable = '0;
   logic [2:0] other_fault_set = '0, lc = '0;
   core_event_type core_event;
   int error_cnt = 0, checks = 0, seed = 32'h0d73b0f3, n, p, e;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [5:0] evq[$];
   watchdog_and_wakeup_control u_watchdog_and_wakeup_control (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .external_low_crystal(external_low_crystal),
      .internal_low_rc_osc(internal_low_rc_osc), .ext_reset_n(ext_reset_n), .usb_reset(usb_reset),
      .porta_in(porta_in), .halt_exec(halt_exec), .watchdog_clear_instruction(watchdog_clear_instruction),
      .int_pending(int_pending), .int_enable(int_enable), .stack_full(stack_full),
      .other_fault_set(other_fault_set), .core_event(core_event), .in_sleep(in_sleep));
   initial forever #5 aclk = ~aclk;
   // The RC clock runs at a quarter and the crystal at an eighth of the bus clock.
   always @(posedge aclk) begin
      lc <= lc + 3'h1;
      if (rc_run) internal_low_rc_osc <= lc[1];
      external_low_crystal <= lc[2];
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task fail_wait;
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      end_sim;
   endtask
   task axi_w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      logic aw, w;
      @(posedge aclk);
      bq.push_back(r);
      aw = 0;
      w = 0;
      i = 0;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (i++ > 50) fail_wait;
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 0;
         end
      end while (!(aw && w));
      while (!s_axi_bvalid) begin
         @(posedge aclk);
         if (i++ > 100) fail_wait;
      end
      s_axi_bready <= 0;
   endtask
   task axi_r(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      @(posedge aclk);
      rq.push_back({r, d});
      i = 0;
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (i++ > 50) fail_wait;
      end while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do begin
         @(posedge aclk);
         if (i++ > 100) fail_wait;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
   endtask
   task halt;
      @(posedge aclk);
      halt_exec <= 1;
      @(posedge aclk);
      halt_exec <= 0;
   endtask
   task clr;
      @(posedge aclk);
      watchdog_clear_instruction <= 1;
      @(posedge aclk);
      watchdog_clear_instruction <= 0;
   endtask
   task wait_ev(input int lim);
      for (n = 0; evq.size() != 0; n++) begin
         @(posedge aclk);
         if (n > lim) fail_wait;
      end
   endtask
   // Every read, write answer and core event is matched against the oldest note.
   always @(posedge aclk) begin
      if (aresetn && s_axi_rvalid && s_axi_rready) begin
         check(s_axi_rdata, rq[0][31:0]);
         check(32'(s_axi_rresp), 32'(rq[0][33:32]));
         void'(rq.pop_front());
      end
      if (aresetn && s_axi_bvalid && s_axi_bready) check(32'(s_axi_bresp), 32'(bq.pop_front()));
      if (aresetn && core_event !== '0) check(32'(core_event), evq.size() ? 32'(evq.pop_front()) : 32'h0);
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      for (int k = 0; k < 6; k++) axi_r(8'(4 * k), (k == 0) ? 32'h53 : 32'h0, (k == 5) ? RESP_SLVERR : RESP_OKAY);
      axi_w(8'h14, 32'h0, RESP_SLVERR);
      axi_w(STATUS_OFFSET, 32'hff, RESP_OKAY);
      // A write without the low byte lane must leave the key untouched, or a key fault would follow.
      s_axi_wstrb <= 4'($random(seed)) & 4'he;
      axi_w(CTRL_OFFSET, 32'h0, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axi_r(CTRL_OFFSET, 32'h53, RESP_OKAY);
      axi_r(STATUS_OFFSET, 32'h0, RESP_OKAY);
      $display("test registers finished");
      rc_run <= 0;
      axi_w(CLKSEL_OFFSET, 32'h1, RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
         e = (k == 0) ? 2048 : 8192;
         axi_w(CTRL_OFFSET, {24'h0, KEY_ENABLE, 3'(k)}, RESP_OKAY);
         clr;
         evq.push_back(6'h28);
         wait_ev(e + 100);
         check(32'(n >= e - 10 && n <= e + 30), 32'h1);
         axi_r(STATUS_OFFSET, 32'h1, RESP_OKAY);
      end
      axi_w(CTRL_OFFSET, {24'h0, KEY_ENABLE, 3'h0}, RESP_OKAY);
      repeat (4) begin
         clr;
         repeat (1500) @(posedge aclk);
      end
      $display("test timeout finished");
      rc_run <= 1;
      axi_w(CLKSEL_OFFSET, 32'h0, RESP_OKAY);
      axi_w(CTRL_OFFSET, {24'h0, KEY_DISABLE, 3'h0}, RESP_OKAY);
      halt;
      axi_r(STATUS_OFFSET, 32'h6, RESP_OKAY);
      check(32'(in_sleep), 32'h1);
      repeat (1500) @(posedge aclk);
      p = $unsigned($random(seed)) % 8;
      axi_w(WAKE_EN_OFFSET, 32'h1 << p, RESP_OKAY);
      porta_in <= ~(8'h1 << (p ^ 1));
      repeat (8) @(posedge aclk);
      evq.push_back(6'h06);
      porta_in <= ~((8'h1 << p) | (8'h1 << (p ^ 1)));
      wait_ev(40);
      porta_in <= 8'hff;
      clr;
      axi_r(STATUS_OFFSET, 32'h0, RESP_OKAY);
      $display("test port wake finished");
      for (int k = 0; k < 3; k++) begin
         p = $unsigned($random(seed)) % 8;
         int_pending <= 8'h1 << (p ^ 1);
         int_enable <= (k == 1) ? 8'h0 : 8'hff;
         stack_full <= (k == 2);
         halt;
         repeat (8) @(posedge aclk);
         evq.push_back((k == 0) ? 6'h05 : 6'h06);
         int_pending <= (8'h1 << p) | (8'h1 << (p ^ 1));
         wait_ev(40);
         int_pending <= 8'h0;
         clr;
      end
      $display("test interrupt wake finished");
      for (int k = 0; k < 2; k++) begin
         halt;
         // A pin or bus reset while asleep is both a wake and a full reset.
         evq.push_back(6'h2c);
         if (k == 0) ext_reset_n <= 0;
         else usb_reset <= 1;
         wait_ev(40);
         ext_reset_n <= 1;
         usb_reset <= 0;
         clr;
      end
      axi_w(CTRL_OFFSET, {24'h0, KEY_ENABLE, 3'h0}, RESP_OKAY);
      halt;
      evq.push_back(6'h1c);
      wait_ev(1200);
      check(32'(n >= 1010 && n <= 1050), 32'h1);
      axi_r(STATUS_OFFSET, 32'h3, RESP_OKAY);
      $display("test sleep overflow finished");
      axi_w(CTRL_OFFSET, 32'h0, RESP_OKAY);
      evq.push_back(6'h28);
      wait_ev(40);
      check(32'(n >= 3 && n <= 24), 32'h1);
      axi_r(FLAGS_OFFSET, 32'h1, RESP_OKAY);
      axi_r(CTRL_OFFSET, 32'h53, RESP_OKAY);
      other_fault_set <= 3'h5;
      @(posedge aclk);
      other_fault_set <= 3'h0;
      axi_r(FLAGS_OFFSET, 32'hb, RESP_OKAY);
      axi_w(FLAGS_OFFSET, 32'ha, RESP_OKAY);
      axi_r(FLAGS_OFFSET, 32'ha, RESP_OKAY);
      $display("test key fault finished");
      end_sim;
   end
endmodule

// ### wdt_checker.sv
`timescale 1ns/100ps
module wdt_checker
   import wdt_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core side.
   input wire logic halt_exec,
   input wire core_event_type core_event,
   input wire logic in_sleep
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_pc_clear_pair: assert property (core_event.pc_clear == (core_event.full_reset || core_event.pc_sp_reset))
      else $error("program counter clear unpaired");
   a_sleep_reset_kind: assert property (core_event.pc_sp_reset |-> core_event.wake && !core_event.full_reset)
      else $error("sleep overflow gave wrong reset");
   a_resume_kind: assert property (core_event.resume_next || core_event.int_vector |-> core_event.wake)
      else $error("resume without wake");
   a_one_resume: assert property (!(core_event.resume_next && core_event.int_vector))
      else $error("two resume kinds at once");
   a_wake_asleep: assert property (core_event.wake |-> in_sleep || $past(in_sleep))
      else $error("wake while awake");
   a_halt_sleeps: assert property (halt_exec && !in_sleep |-> ##[1:3] in_sleep)
      else $error("halt did not sleep");
   a_wake_pulse: assert property (core_event.wake |=> !core_event.wake)
      else $error("wake longer than one cycle");
   c_vector: cover property (core_event.int_vector);
   c_sleep_overflow: cover property (core_event.pc_sp_reset);
   c_full_reset: cover property (core_event.full_reset);
endmodule
bind watchdog_and_wakeup_control wdt_checker u_wdt_checker (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .halt_exec(halt_exec), .core_event(core_event), .in_sleep(in_sleep));

// ### wdt_pkg.sv
package wdt_pkg;

   // Register byte offsets.
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] FLAGS_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] CLKSEL_OFFSET = 8'h0c;
   localparam logic [7:0] WAKE_EN_OFFSET = 8'h10;

   // Control register layout and values.
   localparam logic [7:0] CTRL_RESET = 8'h53;
   localparam int unsigned KEY_LSB = 3;
   localparam int unsigned KEY_W = 5;
   localparam int unsigned SEL_W = 3;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [4:0] KEY_ENABLE = 5'h0a;

   // Reset cause flag bits.
   localparam int unsigned FLAG_KEY_FAULT = 0;
   localparam int unsigned FLAGS_W = 4;
   localparam int unsigned EXT_FLAGS_W = 3;

   // Status register bits.
   localparam int unsigned STAT_TIMEOUT = 0;
   localparam int unsigned STAT_POWER_DOWN = 1;
   localparam int unsigned STAT_ASLEEP = 2;

   // Counter and key fault timing.
   localparam int unsigned CNT_W = 18;
   localparam logic [1:0] KEY_FAULT_EDGES = 2'h2;

   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic full_reset;
      logic pc_sp_reset;
      logic pc_clear;
      logic wake;
      logic resume_next;
      logic int_vector;
   } core_event_type;

   function automatic logic [4:0] period_exp(input logic [2:0] sel);
      case (sel)
         3'h0: period_exp = 5'h08;
         3'h1: period_exp = 5'h0a;
         3'h2: period_exp = 5'h0c;
         3'h3: period_exp = 5'h0e;
         3'h4: period_exp = 5'h0f;
         3'h5: period_exp = 5'h10;
         3'h6: period_exp = 5'h11;
         default: period_exp = 5'h12;
      endcase
   endfunction

endpackage
